// *** src/feedback_pkg.sv ***
package feedback_pkg;

  // logic execution cycle is one clock at 20 MHz
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYCLE_NS        = 1_000_000_000 / CLK_HZ;
  // debounce time in microseconds, counted in whole cycles (least time rounds up)
  localparam int unsigned DEBOUNCE_US     = 12_000;
  localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * 1000 + CYCLE_NS - 1) / CYCLE_NS;
  // window step in microseconds and its length in cycles
  localparam int unsigned WINDOW_STEP_US  = 10_000;
  localparam int unsigned WINDOW_STEP_CYC = (WINDOW_STEP_US * 1000) / CYCLE_NS;
  // window setting range, in 10 ms steps: 100 s to 1000 s
  localparam int unsigned WINDOW_MIN_STEPS = 10_000;
  localparam int unsigned WINDOW_MAX_STEPS = 100_000;
  localparam int unsigned STEPS_W          = 17;
  localparam int unsigned CNT_W            = 24;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON_WAIT,
    ST_ON,
    ST_OFF_WAIT
  } mon_state_e;

  typedef struct packed {
    logic request;
    logic feedback;
  } mon_in_s;

  typedef struct packed {
    logic actuate;
    logic fault;
    logic fault_flag;
  } mon_out_s;

endpackage

// *** src/cycle_timer.sv ***
// counts cycles while run is high, restarting from zero when run drops
module cycle_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  expired
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (!run) begin
      count_nxt = '0;
    end else if (count_r != limit) begin
      count_nxt = count_r + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // saturates so expiry stays asserted while run holds
  assign expired = run && (count_r == limit);
endmodule

// *** src/window_timer.sv ***
// feedback window: step prescaler plus step counter
module window_timer #(
  parameter int unsigned STEP_CYC = 200_000,
  parameter int unsigned STEPS_W  = 17
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               run,
  input  wire logic [STEPS_W-1:0] steps,
  output logic                    expired
);
  logic [17:0]        pre_r;
  logic [17:0]        pre_nxt;
  logic [STEPS_W-1:0] step_r;
  logic [STEPS_W-1:0] step_nxt;
  logic               tick;

  assign tick = (pre_r == 18'(STEP_CYC - 1));

  always_comb begin
    pre_nxt  = pre_r;
    step_nxt = step_r;
    if (!run) begin
      pre_nxt  = '0;
      step_nxt = '0;
    end else if (step_r != steps) begin
      pre_nxt = tick ? 18'h0_0000 : pre_r + 18'h0_0001;
      if (tick) begin
        step_nxt = step_r + STEPS_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r  <= '0;
      step_r <= '0;
    end else begin
      pre_r  <= pre_nxt;
      step_r <= step_nxt;
    end
  end

  assign expired = run && (step_r == steps);
endmodule

// *** src/external_device_check.sv ***
// Operation
// - debounce applies after window expiry; code runs it in ST_OFF/ST_ON, also when feedback ends the window early
// - window set in 10 ms steps, above cycle
// - actuate after feedback high, request rising
// - actuate low on request low or fault
// - fault at once if feedback low at rise
// - fault if feedback not falling within window
// - fault if feedback not rising within window
// - request low, feedback low past debounce: fault
// - request high, feedback high past debounce: fault
// - fault and flag asserted together
// - fault clears only on valid actuation sequence
module external_device_check #(
  parameter int unsigned STEP_CYC     = feedback_pkg::WINDOW_STEP_CYC,
  parameter int unsigned DEBOUNCE_CYC = feedback_pkg::DEBOUNCE_CYC
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             control_request_in,
  input  wire logic                             contactor_feedback_in,
  input  wire logic [feedback_pkg::STEPS_W-1:0] feedback_window,
  output logic                                  actuation_out,
  output logic                                  feedback_fault_out,
  output logic                                  fault_flag_out,
  output logic                                  window_setting_bad
);
  feedback_pkg::mon_in_s    in_now;
  feedback_pkg::mon_state_e state_r;
  feedback_pkg::mon_state_e state_nxt;
  feedback_pkg::mon_out_s   out_r;
  feedback_pkg::mon_out_s   out_nxt;
  logic                     req_prev_r;
  logic                     req_prev_nxt;
  logic [feedback_pkg::STEPS_W-1:0] window_eff;
  logic                     rise;
  logic                     fall;
  logic                     win_run;
  logic                     win_expired;
  logic                     bounce_run;
  logic                     bounce_expired;
  logic                     set_fault;
  logic                     good_start;

  assign in_now.request  = control_request_in;
  assign in_now.feedback = contactor_feedback_in;

  assign rise = in_now.request && !req_prev_r;
  assign fall = !in_now.request && req_prev_r;

  // clamp window into its legal range
  always_comb begin
    window_eff         = feedback_window;
    window_setting_bad = 1'b0;
    if (feedback_window < feedback_pkg::STEPS_W'(feedback_pkg::WINDOW_MIN_STEPS)) begin
      window_eff         = feedback_pkg::STEPS_W'(feedback_pkg::WINDOW_MIN_STEPS);
      window_setting_bad = 1'b1;
    end else if (feedback_window > feedback_pkg::STEPS_W'(feedback_pkg::WINDOW_MAX_STEPS)) begin
      window_eff         = feedback_pkg::STEPS_W'(feedback_pkg::WINDOW_MAX_STEPS);
      window_setting_bad = 1'b1;
    end
  end

  // window runs while awaiting the inverted feedback
  assign win_run = (state_r == feedback_pkg::ST_ON_WAIT) ||
                   (state_r == feedback_pkg::ST_OFF_WAIT);

  window_timer #(
    .STEP_CYC (STEP_CYC),
    .STEPS_W  (feedback_pkg::STEPS_W)
  ) u_window (
    .clk     (clk),
    .rst     (rst),
    .run     (win_run),
    .steps   (window_eff),
    .expired (win_expired)
  );

  // wrong level while settled starts debounce
  assign bounce_run =
    ((state_r == feedback_pkg::ST_OFF) && !in_now.request && !in_now.feedback) ||
    ((state_r == feedback_pkg::ST_ON) && in_now.request && in_now.feedback);

  // debounce only once the window is over
  cycle_timer #(
    .WIDTH (feedback_pkg::CNT_W)
  ) u_bounce (
    .clk     (clk),
    .rst     (rst),
    .run     (bounce_run),
    .limit   (feedback_pkg::CNT_W'(DEBOUNCE_CYC)),
    .expired (bounce_expired)
  );

  // valid sequence: feedback high at request rise
  assign good_start = rise && in_now.feedback;

  always_comb begin
    state_nxt    = state_r;
    req_prev_nxt = in_now.request;
    set_fault    = 1'b0;
    case (state_r)
      feedback_pkg::ST_OFF: begin
        if (rise) begin
          if (!in_now.feedback) begin
            set_fault = 1'b1;
          end
          state_nxt = feedback_pkg::ST_ON_WAIT;
        end else if (bounce_expired) begin
          set_fault = 1'b1;
        end
      end
      feedback_pkg::ST_ON_WAIT: begin
        if (fall) begin
          state_nxt = feedback_pkg::ST_OFF_WAIT;
        end else if (!in_now.feedback) begin
          state_nxt = feedback_pkg::ST_ON;
        end else if (win_expired) begin
          set_fault = 1'b1;
          state_nxt = feedback_pkg::ST_ON;
        end
      end
      feedback_pkg::ST_ON: begin
        if (fall) begin
          state_nxt = feedback_pkg::ST_OFF_WAIT;
        end else if (bounce_expired) begin
          set_fault = 1'b1;
        end
      end
      feedback_pkg::ST_OFF_WAIT: begin
        if (rise) begin
          // a new request before release still needs feedback high
          set_fault = !in_now.feedback;
          state_nxt = feedback_pkg::ST_ON_WAIT;
        end else if (in_now.feedback) begin
          state_nxt = feedback_pkg::ST_OFF;
        end else if (win_expired) begin
          set_fault = 1'b1;
          state_nxt = feedback_pkg::ST_OFF;
        end
      end
      default: begin
        state_nxt = feedback_pkg::ST_OFF;
      end
    endcase
  end

  always_comb begin
    out_nxt = out_r;
    // clear only on a valid start, but a new fault wins
    if (good_start) begin
      out_nxt.fault      = 1'b0;
      out_nxt.fault_flag = 1'b0;
    end
    if (set_fault) begin
      out_nxt.fault      = 1'b1;
      out_nxt.fault_flag = 1'b1;
    end
    // actuation follows request, blocked by fault
    if (!in_now.request || out_nxt.fault) begin
      out_nxt.actuate = 1'b0;
    end else if (good_start) begin
      out_nxt.actuate = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= feedback_pkg::ST_OFF;
      out_r      <= '0;
      req_prev_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      out_r      <= out_nxt;
      req_prev_r <= req_prev_nxt;
    end
  end

  assign actuation_out      = out_r.actuate;
  assign feedback_fault_out = out_r.fault;
  assign fault_flag_out     = out_r.fault_flag;
endmodule

// *** verification/monitor_sva.sv ***
module monitor_sva #(
  parameter int unsigned STEP_CYC     = 1,
  parameter int unsigned DEBOUNCE_CYC = 6
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        control_request_in,
  input wire logic        contactor_feedback_in,
  input wire logic [16:0] feedback_window,
  input wire logic        actuation_out,
  input wire logic        feedback_fault_out,
  input wire logic        fault_flag_out,
  input wire logic        window_setting_bad
);
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic        req_r;

  // consecutive cycles of wrong level since the last request change or the last cycle of right level
  always_comb begin
    cnt_nxt = cnt_r + 24'h00_0001;
    if (control_request_in != req_r || control_request_in != contactor_feedback_in) begin
      cnt_nxt = 24'h00_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 24'h00_0000;
      req_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      req_r <= control_request_in;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  flag_match_a: assert property (
    fault_flag_out == feedback_fault_out) else $error("fault flag differs");
  req_low_a: assert property (
    !control_request_in |=> !actuation_out) else $error("actuation with request low");
  fault_off_a: assert property (
    feedback_fault_out |-> !actuation_out) else $error("actuation with fault");
  act_rise_a: assert property (
    $rose(actuation_out) |-> $past(rst, 2) || ($past(control_request_in)
      && !$past(control_request_in, 2) && $past(contactor_feedback_in)))
    else $error("actuation without valid start");
  low_start_a: assert property (
    $rose(control_request_in) && !contactor_feedback_in |-> ##1 feedback_fault_out)
    else $error("no fault on start with feedback low");
  good_start_a: assert property (
    $rose(control_request_in) && contactor_feedback_in |=> actuation_out && !feedback_fault_out)
    else $error("valid start not taken");
  fault_hold_a: assert property (
    feedback_fault_out && !($rose(control_request_in) && contactor_feedback_in)
      |=> feedback_fault_out) else $error("fault dropped early");
  late_fault_a: assert property (
    !window_setting_bad && cnt_r >= {7'h00, feedback_window} * STEP_CYC + DEBOUNCE_CYC + 4
      |-> feedback_fault_out) else $error("wrong feedback not faulted");
  window_bad_a: assert property (
    window_setting_bad == (feedback_window < feedback_pkg::WINDOW_MIN_STEPS
      || feedback_window > feedback_pkg::WINDOW_MAX_STEPS)) else $error("window check wrong");

  cover property ($rose(actuation_out));
  cover property ($rose(feedback_fault_out));
  cover property ($rose(window_setting_bad));
endmodule

bind external_device_check monitor_sva #(.STEP_CYC(STEP_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_sva (
  .clk(clk), .rst(rst), .control_request_in(control_request_in),
  .contactor_feedback_in(contactor_feedback_in), .feedback_window(feedback_window),
  .actuation_out(actuation_out), .feedback_fault_out(feedback_fault_out),
  .fault_flag_out(fault_flag_out), .window_setting_bad(window_setting_bad));

// *** verification/contactor_model.sv ***
module contactor_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        actuate,
  input  wire logic        glitch,
  input  wire logic [15:0] lag,
  output logic             feedback
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        fb_r;
  logic [15:0] cnt_r;

  // glitch inverts the contact only while the bench commands it
  assign feedback = fb_r ^ glitch;

  // contact opens when the coil pulls in and closes when it drops, lag+1 cycles later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_r <= 1'b1;
      cnt_r <= 16'h0000;
    end else if (fb_r != actuate) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r >= lag) begin
      fb_r <= ~fb_r;
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule

// *** verification/test_external_device_check.sv ***
module test_external_device_check;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic                    g;
    logic                    req;
    logic [15:0]             lag;
    logic [15:0]             w;
    feedback_pkg::mon_out_s  e;
  } row_s;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    req = 1'b0;
  logic                    glitch = 1'b0;
  logic [15:0]             lag = 16'h0002;
  logic [16:0]             feedback_window = 17'h0_2710;
  logic                    fb;
  logic                    actuation_out;
  logic                    feedback_fault_out;
  logic                    fault_flag_out;
  logic                    window_setting_bad;
  feedback_pkg::mon_out_s  outs;
  int                      failures = 0;
  int                      checked = 0;
  row_s                    rows [20] = '{
    '{1'b0, 1'b1, 16'h0002, 16'h0014, 3'b100}, '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b000},
    '{1'b0, 1'b1, 16'h2328, 16'h238C, 3'b100}, '{1'b0, 1'b0, 16'h2328, 16'h238C, 3'b000},
    '{1'b0, 1'b1, 16'h2AF8, 16'h2774, 3'b011}, '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b011},
    '{1'b0, 1'b1, 16'h0002, 16'h0014, 3'b100}, '{1'b1, 1'b1, 16'h0002, 16'h0004, 3'b100},
    '{1'b0, 1'b1, 16'h0002, 16'h0003, 3'b100}, '{1'b1, 1'b1, 16'h0002, 16'h000C, 3'b011},
    '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b011}, '{1'b0, 1'b1, 16'h0002, 16'h0014, 3'b100},
    '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b000}, '{1'b1, 1'b1, 16'h0002, 16'h0004, 3'b011},
    '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b011}, '{1'b0, 1'b1, 16'h0002, 16'h0014, 3'b100},
    '{1'b0, 1'b0, 16'h0002, 16'h0014, 3'b000}, '{1'b1, 1'b0, 16'h0002, 16'h000C, 3'b011},
    '{1'b0, 1'b1, 16'h0002, 16'h0014, 3'b100}, '{1'b0, 1'b0, 16'h2AF8, 16'h2774, 3'b011}};

  always #25 clk = ~clk;
  assign outs = {actuation_out, feedback_fault_out, fault_flag_out};

  // short window and debounce keep the run small
  external_device_check #(.STEP_CYC(1), .DEBOUNCE_CYC(6)) u_dut (
    .clk(clk), .rst(rst), .control_request_in(req), .contactor_feedback_in(fb),
    .feedback_window(feedback_window), .actuation_out(actuation_out),
    .feedback_fault_out(feedback_fault_out), .fault_flag_out(fault_flag_out),
    .window_setting_bad(window_setting_bad));
  contactor_model u_model (
    .clk(clk), .rst(rst), .actuate(actuation_out), .glitch(glitch), .lag(lag), .feedback(fb));

  task check(feedback_pkg::mon_out_s seen, feedback_pkg::mon_out_s exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    // rows need about 39000 cycles; 50000 leaves margin
    #2_500_000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      glitch <= rows[i].g;
      req <= rows[i].req;
      lag <= rows[i].lag;
      repeat (rows[i].w) @(posedge clk);
      #1 check(outs, rows[i].e);
    end
    // request already high at release counts as a rising edge
    @(posedge clk);
    rst <= 1'b1;
    lag <= 16'h0002;
    req <= 1'b1;
    @(posedge clk);
    #1 check(outs, 3'b000);
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(outs, 3'b100);
    @(posedge clk);
    feedback_window <= 17'h0_0005;
    @(posedge clk);
    #1 check({2'b00, window_setting_bad}, 3'b001);
    @(posedge clk);
    feedback_window <= 17'h0_2710;
    @(posedge clk);
    #1 check({2'b00, window_setting_bad}, 3'b000);
    end_sim();
  end
endmodule
